// ---- hw/spcr_top.sv ----
/*
  serial control port with configuration, identification and readback
  bank selection registers.
  assumes the host drives chip select low for a transfer, shifts a 16-bit
  instruction (rw, two width bits, 13 address bits) and then data bytes.
  the serial clock is sampled by core_clk and must run well below it.
*/
`timescale 1ns/1ps
module spcr_top
  import spcr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic sclk_pin, // serial clock from host
  input wire logic cs_n_pin, // chip select, active low
  input wire logic sdio_i, // data pin level in
  output logic sdio_o, // data pin drive value
  output logic sdio_oe, // data pin drive enable
  output logic serial_output_pin_o, // dedicated output value
  output logic serial_output_pin_oe, // dedicated output enable
  output logic [7:0] active_cfg, // active configuration byte
  output logic active_rb_sel // active readback select
);
  logic [2:0] pins_s;
  logic sclk_s;
  logic cs_n_s;
  logic sdi_s;
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic rise;
  logic fall;

  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  spcr_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d_in({sclk_pin, cs_n_pin, sdio_i}),
    .d_out(pins_s)
  );
  assign sclk_s = pins_s[2];
  assign cs_n_s = pins_s[1];
  assign sdi_s = pins_s[0];
  // serial clock edges count only inside a frame
  assign rise = sclk_s && !sclk_d_r && !cs_n_s;
  assign fall = !sclk_s && sclk_d_r && !cs_n_s;

  // ---------------------------------------------------------------
  // register banks
  // ---------------------------------------------------------------
  logic [7:0] cfg_buf_r;
  logic [7:0] cfg_buf_nxt;
  logic [7:0] cfg_act_r;
  logic [7:0] cfg_act_nxt;
  logic [7:0] rb_buf_r;
  logic [7:0] rb_buf_nxt;
  logic [7:0] rb_act_r;
  logic [7:0] rb_act_nxt;
  logic [7:0] upd_r;
  logic [7:0] upd_nxt;

  // ---------------------------------------------------------------
  // transfer engine
  // ---------------------------------------------------------------
  spcr_state_t st_r;
  spcr_state_t st_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [15:0] instr_r;
  logic [15:0] instr_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [12:0] addr_r;
  logic [12:0] addr_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic out_r;
  logic out_nxt;
  logic drive_r;
  logic drive_nxt;
  logic sdio_o_r;
  logic sdio_o_nxt;
  logic sdio_oe_r;
  logic sdio_oe_nxt;
  logic so_o_r;
  logic so_o_nxt;
  logic so_oe_r;
  logic so_oe_nxt;

  logic lsb_first;
  logic in_reset;
  assign lsb_first = cfg_buf_r[spcr_bit_lsb_first];
  assign in_reset = cfg_buf_r[spcr_bit_soft_rst];

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // read value of one address from the selected bank
  function automatic logic [7:0] rd_val(input logic [12:0] a,
                                        input logic act);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      spcr_off_cfg: v = act ? cfg_act_r : cfg_buf_r;
      spcr_off_part_identification: v = spcr_part_identification_val;
      spcr_off_rb_sel: v = act ? rb_act_r : rb_buf_r;
      spcr_off_update: v = upd_r;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // next address after a byte in the chosen stepping direction
  function automatic logic [12:0] step(input logic [12:0] a,
                                       input logic inc);
    return inc ? a + 13'h001 : a - 13'h001;
  endfunction

  // bit to send: msb or lsb of the shift value
  function automatic logic tx_bit(input logic [7:0] v, input logic lsb);
    return lsb ? v[0] : v[7];
  endfunction

  // shift one bit into a byte in the chosen order
  function automatic logic [7:0] shift_in(input logic [7:0] v,
                                          input logic b,
                                          input logic lsb);
    return lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  // config byte from its low nibble: long bit forced, upper nibble mirrored
  function automatic logic [7:0] mirror_cfg(input logic [3:0] lo);
    logic [3:0] n;
    n = lo;
    n[spcr_bit_long] = 1'b1;
    return {n[0], n[1], n[2], n[3], n};
  endfunction

  always_comb begin
    logic [7:0] wb;
    logic [7:0] nb;
    wb = 8'h00;
    nb = 8'h00;
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    instr_nxt = instr_r;
    sh_nxt = sh_r;
    addr_nxt = addr_r;
    tx_nxt = tx_r;
    out_nxt = out_r;
    drive_nxt = drive_r;
    cfg_buf_nxt = cfg_buf_r;
    cfg_act_nxt = cfg_act_r;
    rb_buf_nxt = rb_buf_r;
    rb_act_nxt = rb_act_r;
    upd_nxt = upd_r;
    if (upd_r[spcr_bit_update]) begin
      cfg_act_nxt = cfg_buf_r;
      rb_act_nxt = rb_buf_r;
      upd_nxt = spcr_update_rst;
    end
    if (cs_n_s) begin
      // a partial byte is dropped when select rises
      st_nxt = spcr_st_instr;
      cnt_nxt = 5'h00;
      drive_nxt = 1'b0;
    end else begin
      unique case (st_r)
        spcr_st_instr: begin
          if (rise) begin
            // instruction always 16 bits, msb first
            instr_nxt = {instr_r[14:0], sdi_s};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(spcr_instr_bits - 1)) begin
              st_nxt = spcr_st_data;
              cnt_nxt = 5'h00;
              addr_nxt = instr_r[11:0] == 12'h000 && sdi_s == 1'b0
                ? 13'h000 : {instr_r[11:0], sdi_s};
              tx_nxt = rd_val({instr_r[11:0], sdi_s},
                              rb_buf_r[spcr_bit_rb_active]);
              out_nxt = tx_bit(tx_nxt, lsb_first);
              drive_nxt = instr_r[14]; // read when top bit set
            end
          end
        end
        spcr_st_data: begin
          if (rise) begin
            sh_nxt = shift_in(sh_r, sdi_s, lsb_first);
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(spcr_data_bits - 1)) begin
              wb = shift_in(sh_r, sdi_s, lsb_first);
              cnt_nxt = 5'h00;
              if (!instr_r[15]) begin
                unique case (addr_r)
                  spcr_off_cfg: begin
                    // upper nibble rebuilt from the low one, so it mirrors
                    nb = mirror_cfg(wb[3:0]);
                    cfg_buf_nxt = nb;
                    cfg_act_nxt = nb;
                  end
                  spcr_off_rb_sel:
                    if (!in_reset) begin
                      rb_buf_nxt = {7'h00, wb[spcr_bit_rb_active]};
                    end
                  spcr_off_update:
                    if (!in_reset) begin
                      upd_nxt = {7'h00, wb[spcr_bit_update]};
                    end
                  default: ;
                endcase
              end
              addr_nxt = step(addr_r, lsb_first);
              tx_nxt = rd_val(step(addr_r, lsb_first),
                              rb_buf_r[spcr_bit_rb_active]);
            end
          end
          if (fall && drive_r) begin
            out_nxt = tx_bit(tx_r, lsb_first);
            tx_nxt = shift_in(tx_r, 1'b0, lsb_first);
          end
        end
        default: st_nxt = spcr_st_instr;
      endcase
    end
    if (cfg_buf_r[spcr_bit_soft_rst]) begin
      // hold other registers at defaults while reset bit set
      rb_buf_nxt = spcr_rb_sel_rst;
      rb_act_nxt = spcr_rb_sel_rst;
      upd_nxt = spcr_update_rst;
    end
    if (!nrst) begin
      st_nxt = spcr_st_instr;
      cnt_nxt = 5'h00;
      instr_nxt = 16'h0000;
      sh_nxt = 8'h00;
      addr_nxt = 13'h000;
      tx_nxt = 8'h00;
      out_nxt = 1'b0;
      drive_nxt = 1'b0;
      cfg_buf_nxt = spcr_cfg_rst;
      cfg_act_nxt = spcr_cfg_rst;
      rb_buf_nxt = spcr_rb_sel_rst;
      rb_act_nxt = spcr_rb_sel_rst;
      upd_nxt = spcr_update_rst;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_comb begin
    sdio_o_nxt = 1'b0;
    sdio_oe_nxt = 1'b0;
    so_o_nxt = 1'b0;
    so_oe_nxt = 1'b0;
    // pin choice follows the buffer copy, so it applies to the next read
    if (cfg_buf_r[spcr_bit_out_sel]) begin
      so_o_nxt = out_nxt;
      so_oe_nxt = drive_nxt;
    end else begin
      sdio_o_nxt = out_nxt;
      sdio_oe_nxt = drive_nxt;
    end
    if (!nrst) begin
      sdio_oe_nxt = 1'b0;
      so_oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    sclk_d_r <= sclk_d_nxt;
    st_r <= st_nxt;
    cnt_r <= cnt_nxt;
    instr_r <= instr_nxt;
    sh_r <= sh_nxt;
    addr_r <= addr_nxt;
    tx_r <= tx_nxt;
    out_r <= out_nxt;
    drive_r <= drive_nxt;
    cfg_buf_r <= cfg_buf_nxt;
    cfg_act_r <= cfg_act_nxt;
    rb_buf_r <= rb_buf_nxt;
    rb_act_r <= rb_act_nxt;
    upd_r <= upd_nxt;
    sdio_o_r <= sdio_o_nxt;
    sdio_oe_r <= sdio_oe_nxt;
    so_o_r <= so_o_nxt;
    so_oe_r <= so_oe_nxt;
  end

  assign sclk_d_nxt = nrst ? sclk_s : 1'b0;
  assign sdio_o = sdio_o_r;
  assign sdio_oe = sdio_oe_r;
  assign serial_output_pin_o = so_o_r;
  assign serial_output_pin_oe = so_oe_r;
  assign active_cfg = cfg_act_r;
  assign active_rb_sel = rb_act_r[spcr_bit_rb_active];
endmodule

// ---- hw/spcr_pkg.sv ----
/*
  package of the serial port configuration block: register offsets, field
  positions, reset values and framing constants.
  assumes a host that frames transfers with an active-low chip select and a
  serial clock that idles low; data is sampled on the rising clock edge.
*/
package spcr_pkg;
  localparam logic [12:0] spcr_off_cfg = 13'h000;
  localparam logic [12:0] spcr_off_part_identification = 13'h003;
  localparam logic [12:0] spcr_off_rb_sel = 13'h004;
  localparam logic [12:0] spcr_off_update = 13'h232;
  localparam int spcr_bit_long = 3;
  localparam int spcr_bit_soft_rst = 2;
  localparam int spcr_bit_lsb_first = 1;
  localparam int spcr_bit_out_sel = 0;
  localparam int spcr_bit_rb_active = 0;
  localparam int spcr_bit_update = 0;
  localparam logic [7:0] spcr_cfg_rst = 8'h18;
  localparam logic [7:0] spcr_rb_sel_rst = 8'h00;
  localparam logic [7:0] spcr_update_rst = 8'h00;
  // arbitrary neutral identification value
  localparam logic [7:0] spcr_part_identification_val = 8'h5a;
  localparam int spcr_instr_bits = 16;
  localparam int spcr_data_bits = 8;
  typedef enum logic [1:0] {
    spcr_st_instr,
    spcr_st_data,
    spcr_st_done
  } spcr_state_t;
endpackage

// ---- hw/spcr_sync.sv ----
/*
  two-flop synchroniser for the serial pins.
  assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module spcr_sync (
  input wire logic core_clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic [2:0] d_in, // async pins
  output logic [2:0] d_out // synchronised pins
);
  logic [2:0] meta_r;
  logic [2:0] meta_nxt;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;

  always_comb begin
    meta_nxt = d_in;
    sync_nxt = meta_r;
    // reset to idle pin levels: clock low, select high, data low
    if (!nrst) begin
      meta_nxt = 3'h2;
      sync_nxt = 3'h2;
    end
  end

  always_ff @(posedge core_clk) begin
    meta_r <= meta_nxt;
    sync_r <= sync_nxt;
  end

  assign d_out = sync_r;
endmodule

// ---- dv/spcr_top_props.sv ----
/*
  concurrent checks on the serial port configuration block ports.
  assumes a bind in the bench top file.
*/
`timescale 1ns/1ps
module spcr_top_props
  import spcr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic nrst, // sync reset, active low
  input wire logic sclk_pin, // serial clock
  input wire logic cs_n_pin, // chip select
  input wire logic sdio_i, // data pin in
  input wire logic sdio_o, // data pin value
  input wire logic sdio_oe, // data pin enable
  input wire logic serial_output_pin_o, // output value
  input wire logic serial_output_pin_oe, // output enable
  input wire logic [7:0] active_cfg, // active config
  input wire logic active_rb_sel // active readback select
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_cfg_long_bit: assert property (active_cfg[spcr_bit_long])
    else $error("long instruction bit clear");
  a_cfg_mirror_ok: assert property (active_cfg[7:4] ==
    {active_cfg[0], active_cfg[1], active_cfg[2], active_cfg[3]})
    else $error("config upper nibble not mirrored");
  a_out_pin_hiz: assert property (!active_cfg[0] &&
    !$past(active_cfg[0]) |-> !serial_output_pin_oe)
    else $error("output pin driven in two-way mode");
  a_sdio_in_only: assert property (active_cfg[0] &&
    $past(active_cfg[0]) |-> !sdio_oe)
    else $error("data pin driven in one-way mode");
  a_idle_no_drive: assert property (cs_n_pin [*8] |->
    !sdio_oe && !serial_output_pin_oe)
    else $error("pin driven outside a frame");
  a_drive_in_frame: assert property ($rose(sdio_oe) ||
    $rose(serial_output_pin_oe) |-> !cs_n_pin)
    else $error("drive began with chip select high");
  a_reset_values: assert property ($rose(nrst) |->
    active_cfg == spcr_cfg_rst && !active_rb_sel)
    else $error("wrong values after reset");
  a_soft_clears: assert property ($rose(active_cfg[2]) |->
    ##[0:1] !active_rb_sel)
    else $error("soft reset left readback select set");
  a_soft_holds: assert property (active_cfg[2] &&
    $past(active_cfg[2]) |-> !active_rb_sel)
    else $error("readback select set during soft reset");
endmodule

// ---- dv/spcr_host.sv ----
/*
  host controller model driving the serial control port.
  assumes the bench resolves the data pins and calls frame per transfer.
*/
`timescale 1ns/1ps
module spcr_host (
  input wire logic core_clk, // core clock
  input wire logic sdio_pin, // resolved data pin
  input wire logic so_pin, // resolved dedicated output
  output logic sclk, // serial clock, idles low
  output logic cs_n, // chip select
  output logic sdio_d // host drive, toggles when released
);
  // ----------------------------------------
  // bit level
  // ----------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdio_d = 1'b0;
  end
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask
  task automatic put_bit(input logic b);
    sdio_d <= b;
    half();
    sclk <= 1'b1;
    half();
    sclk <= 1'b0;
  endtask
  // sample late in the high phase, where the bit has settled
  task automatic get_bit(input logic uni, output logic b);
    sdio_d <= ~sdio_d;
    half();
    sclk <= 1'b1;
    repeat (3) @(posedge core_clk);
    b = uni ? so_pin : sdio_pin;
    @(posedge core_clk);
    sclk <= 1'b0;
  endtask
  // ----------------------------------------
  // transfer
  // ----------------------------------------
  task automatic frame(input logic rd, input logic [12:0] a,
      input logic lsb, input logic uni, input int n,
      input logic [15:0] wd, output logic [15:0] rq);
    logic [15:0] ins;
    logic b;
    int i;
    int k;
    int x;
    ins = {rd, 2'b00, a};
    rq = 16'h0000;
    cs_n <= 1'b0;
    half();
    for (i = 15; i >= 0; i--) put_bit(ins[i]);
    for (k = 0; k < n; k++) begin
      for (i = 0; i < 8; i++) begin
        x = 8 * k + (lsb ? i : 7 - i);
        if (rd) begin
          get_bit(uni, b);
          rq[x] = b;
        end else begin
          put_bit(wd[x]);
        end
      end
    end
    sdio_d <= ~sdio_d;
    half();
    cs_n <= 1'b1;
    repeat (2) half();
  endtask
endmodule

// ---- dv/spcr_top_test.sv ----
/*
  self-checking bench of the serial port configuration block.
  assumes the host model in spcr_host and the checker in spcr_top_props.
*/
`timescale 1ns/1ps
module spcr_top_test;
  import spcr_pkg::*;
  // ----------------------------------------
  // harness
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic sclk, cs_n, sdio_d, sdio_o, sdio_oe, so_o, so_oe, rb;
  logic [7:0] cfg;
  logic [15:0] res_v, got;
  logic [15:0] q[$];
  event res_ev;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 34;
  wire logic sdio_pin = sdio_oe ? sdio_o : sdio_d;
  wire logic so_pin = so_oe ? so_o : ~so_o;
  initial forever #20 core_clk = ~core_clk;
  spcr_top dut (.core_clk(core_clk), .nrst(nrst), .sclk_pin(sclk),
    .cs_n_pin(cs_n), .sdio_i(sdio_pin), .sdio_o(sdio_o),
    .sdio_oe(sdio_oe), .serial_output_pin_o(so_o),
    .serial_output_pin_oe(so_oe), .active_cfg(cfg), .active_rb_sel(rb));
  spcr_host h (.core_clk(core_clk), .sdio_pin(sdio_pin),
    .so_pin(so_pin), .sclk(sclk), .cs_n(cs_n), .sdio_d(sdio_d));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic post(input logic [15:0] v, input logic [15:0] e);
    q.push_back(e);
    res_v = v;
    ->res_ev;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d,
      input logic lsb);
    h.frame(1'b0, a, lsb, 1'b0, 1, {8'h00, d}, got);
  endtask
  task automatic rd(input logic [12:0] a, input int n, input logic lsb,
      input logic uni);
    h.frame(1'b1, a, lsb, uni, n, 16'h0000, got);
  endtask
  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  initial forever begin
    @(res_ev);
    check(res_v, q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] rv;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    post({8'h00, cfg}, {8'h00, spcr_cfg_rst});
    rv = 8'($random(seed));
    wr(spcr_off_part_identification, rv, 1'b0);
    rd(spcr_off_part_identification, 1, 1'b0, 1'b0);
    post(got, {8'h00, spcr_part_identification_val});
    wr(spcr_off_rb_sel, 8'h01, 1'b0);
    post({15'h0000, rb}, 16'h0000);
    rd(spcr_off_rb_sel, 2, 1'b0, 1'b0);
    post(got, {spcr_part_identification_val, 8'h00});
    wr(spcr_off_update, 8'h01, 1'b0);
    post({15'h0000, rb}, 16'h0001);
    rd(spcr_off_update, 1, 1'b0, 1'b0);
    post(got, 16'h0000);
    wr(13'h005, 8'hff, 1'b0);
    post({7'h00, rb, cfg}, {8'h01, spcr_cfg_rst});
    wr(spcr_off_cfg, 8'h99, 1'b0);
    rd(spcr_off_part_identification, 1, 1'b0, 1'b1);
    post(got, {8'h00, spcr_part_identification_val});
    wr(spcr_off_cfg, 8'h5a, 1'b0);
    rd(spcr_off_part_identification, 2, 1'b1, 1'b0);
    post(got, {8'h01, spcr_part_identification_val});
    wr(spcr_off_cfg, 8'h3c, 1'b1);
    wr(spcr_off_rb_sel, 8'h01, 1'b0);
    rd(spcr_off_rb_sel, 1, 1'b0, 1'b0);
    post({7'h00, rb, cfg}, 16'h003c);
    post(got, 16'h0000);
    wr(spcr_off_cfg, 8'h18, 1'b0);
    wr(spcr_off_rb_sel, 8'h01, 1'b0);
    rd(spcr_off_rb_sel, 1, 1'b0, 1'b0);
    post(got, 16'h0000);
    wr(spcr_off_update, 8'h01, 1'b0);
    post({15'h0000, rb}, 16'h0001);
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    post({7'h00, rb, cfg}, {8'h00, spcr_cfg_rst});
    complete_run();
  end
endmodule
bind spcr_top spcr_top_props chk (.core_clk(core_clk), .nrst(nrst),
  .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .sdio_i(sdio_i),
  .sdio_o(sdio_o), .sdio_oe(sdio_oe),
  .serial_output_pin_o(serial_output_pin_o),
  .serial_output_pin_oe(serial_output_pin_oe),
  .active_cfg(active_cfg), .active_rb_sel(active_rb_sel));
